/* File: verilog/pfhc_top.sv */
// pfhc_top: repair header builder, header parser and row parity buffer
// assumes src, tx and rx streams are synchronous to hclk, one word per beat
`timescale 1ns/1ps
module pfhc_top (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  input  wire logic                src_valid,
  output logic                     src_ready,
  input  wire logic [31:0]         src_data,
  input  wire logic                src_last,
  output logic                     tx_valid,
  input  wire logic                tx_ready,
  output logic [31:0]              tx_data,
  output logic                     tx_last,
  input  wire logic                rx_valid,
  output logic                     rx_ready,
  input  wire logic [31:0]         rx_data,
  input  wire logic                rx_last,
  output logic                     rx_drop,
  output logic                     rec_valid,
  output logic                     rec_p,
  output logic                     rec_x,
  output logic [3:0]               rec_cc,
  output logic                     rec_m,
  output logic [6:0]               rec_pt,
  output logic [15:0]              rec_len,
  output logic [31:0]              rec_ts,
  output logic                     blk_valid,
  output logic [31:0]              blk_ssrc,
  output logic [15:0]              blk_base,
  output pfhc_pkg::pfhc_mode_t     blk_mode,
  output logic [108:0]             blk_mask,
  output logic [6:0]               blk_mask_w,
  output logic [7:0]               blk_stride,
  output logic [7:0]               blk_groups,
  input  wire logic [15:0]         cov_seq,
  output logic                     cov_hit
);
  import pfhc_pkg::*;

  logic [31:0] cfg_rec, cfg_tsrec, cfg_src_ssrc, cfg_base, lfsr, ts_cnt, ssrc_rep, cur_ts;
  logic [31:0] drop_cnt, tx_word;
  logic [31:0] par [PAR_WORDS];
  logic [15:0] seq, cur_seq, cov_d, cov_j;
  logic [8:0]  ts_div;
  logic [7:0]  cfg_row_len, row_cnt, wr_addr, rd_addr, blk_left;
  logic [6:0]  cfg_pt;
  logic [4:0]  tx_cnt, tx_cur, tx_total, hdr_n, par_len, widx;
  logic [255:0] col_hit;
  logic cfg_rtx, cfg_fixed, wr_pend, rd_pend, tx_start, tx_busy, tx_adv, tx_done;
  logic cur_rtx, cur_fixed, cur_pay, single, ids_set, row_ready, src_go;
  logic rx_rtx, rx_fixed, blk_done, hit_now;
  pfhc_rx_t rx_st;

  // bus answers at once, never errors
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // address phase capture, write committed in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      rd_pend <= hsel && hready && htrans[1] && !hwrite;
      if (hsel && hready && htrans[1]) begin
        wr_addr <= haddr[7:0];
        rd_addr <= haddr[7:0];
      end
    end
  end

  // read mux of register state; unmapped offsets read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_pend) begin
      case (rd_addr)
        OFF_CTRL:     hrdata = {29'h0000_0000, cfg_fixed, cfg_rtx, tx_busy};
        OFF_REC:      hrdata = {2'h0, cfg_rec[29:0]};
        OFF_TSREC:    hrdata = cfg_tsrec;
        OFF_SRC_SSRC: hrdata = cfg_src_ssrc;
        OFF_BASE:     hrdata = cfg_base;
        OFF_CFG:      hrdata = {16'h0000, cfg_row_len, 1'b0, cfg_pt};
        OFF_STATUS:   hrdata = {seq, 13'h0000, row_ready, tx_busy, ids_set};
        OFF_REP_SSRC: hrdata = ssrc_rep;
        OFF_DROP:     hrdata = drop_cnt;
        default:      hrdata = 32'h0000_0000;
      endcase
    end
  end

  // configuration registers; a start while busy is ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_rec      <= 32'h0000_0000;
      cfg_tsrec    <= 32'h0000_0000;
      cfg_src_ssrc <= 32'h0000_0000;
      cfg_base     <= 32'h0000_0000;
      cfg_rtx      <= 1'b0;
      cfg_fixed    <= 1'b0;
      cfg_pt       <= RST_PT;
      cfg_row_len  <= RST_ROW_LEN;
    end else if (wr_pend) begin
      case (wr_addr)
        OFF_CTRL: begin
          cfg_rtx   <= hwdata[BIT_RTX];
          cfg_fixed <= hwdata[BIT_FIXED];
        end
        OFF_REC:      cfg_rec      <= hwdata;
        OFF_TSREC:    cfg_tsrec    <= hwdata;
        OFF_SRC_SSRC: cfg_src_ssrc <= hwdata;
        OFF_BASE:     cfg_base     <= hwdata;
        OFF_CFG: begin
          cfg_pt      <= hwdata[6:0];
          cfg_row_len <= hwdata[15:8];
        end
        default: ;
      endcase
    end
  end

  assign tx_start = wr_pend && (wr_addr == OFF_CTRL) && hwdata[BIT_START] && !tx_busy;

  // free running generator; first send time makes the picked values unpredictable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) lfsr <= LFSR_SEED;
    else lfsr <= {lfsr[30:0], 1'b0} ^ (lfsr[31] ? LFSR_TAPS : 32'h0000_0000);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ts_div <= 9'h000;
      ts_cnt <= 32'h0000_0000;
    end else if (ts_div == 9'(TS_DIV_CYC - 1)) begin
      ts_div <= 9'h000;
      ts_cnt <= ts_cnt + 32'h0000_0001;
    end else begin
      ts_div <= ts_div + 9'h001;
    end
  end

  // sequence and repair identifier, picked once on the first send
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ids_set  <= 1'b0;
      seq      <= 16'h0000;
      cur_seq  <= 16'h0000;
      ssrc_rep <= 32'h0000_0000;
    end else if (tx_start) begin
      ids_set <= 1'b1;
      if (ids_set) begin
        cur_seq <= seq;
        seq     <= seq + 16'h0001;
      end else begin
        cur_seq <= lfsr[15:0];
        seq     <= lfsr[15:0] + 16'h0001;
        ssrc_rep <= {lfsr[15:0], lfsr[31:16]};
      end
    end
  end

  assign single   = cur_rtx && cur_fixed;
  assign hdr_n    = single ? RTX_WORDS : HDR_WORDS;
  assign tx_total = hdr_n + (cur_pay ? par_len : 5'h00);
  assign tx_adv   = !tx_valid || tx_ready;
  assign tx_done  = tx_busy && tx_adv && (tx_cnt == tx_total);

  // word builder for the emitted frame
  always_comb begin
    tx_word = par[4'(tx_cnt - hdr_n)];
    case (tx_cnt)
      W_RTP0: tx_word = {RTP_VER, 1'b0, 1'b0, 4'h0, 1'b0, cfg_pt, cur_seq};
      W_TS:   tx_word = cur_ts;
      W_SSRC: tx_word = ssrc_rep;
      W_FH0:  tx_word = {cur_rtx, cur_fixed, cfg_rec[29:16],
                         single ? cfg_base[31:16] : cfg_rec[15:0]};
      W_FH1:  tx_word = cfg_tsrec;
      W_FH2:  tx_word = single ? cfg_src_ssrc : {8'h01, 24'h00_0000};
      W_SRC:  tx_word = cfg_src_ssrc;
      // fixed offsets or one final 15-bit chunk
      W_BLK:  tx_word = cur_fixed ? cfg_base : {cfg_base[31:16], 1'b1, cfg_base[14:0]};
      default: ;
    endcase
  end

  // output stage; data only changes when the sink took the last word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_busy   <= 1'b0;
      tx_valid  <= 1'b0;
      tx_last   <= 1'b0;
      tx_data   <= 32'h0000_0000;
      tx_cnt    <= 5'h00;
      tx_cur    <= 5'h00;
      cur_rtx   <= 1'b0;
      cur_fixed <= 1'b0;
      cur_pay   <= 1'b0;
      cur_ts    <= 32'h0000_0000;
    end else if (tx_start) begin
      tx_busy   <= 1'b1;
      tx_cnt    <= 5'h00;
      cur_rtx   <= cfg_rtx;
      cur_fixed <= cfg_fixed;
      cur_pay   <= row_ready && !(cfg_rtx && cfg_fixed);
      cur_ts    <= ts_cnt;
    end else if (tx_done) begin
      tx_busy  <= 1'b0;
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end else if (tx_busy && tx_adv) begin
      tx_valid <= 1'b1;
      tx_data  <= tx_word;
      tx_last  <= (tx_cnt + 5'h01) == tx_total;
      tx_cnt   <= tx_cnt + 5'h01;
      tx_cur   <= tx_cnt;
    end
  end

  // row parity: first packet stores, later packets fold in by xor
  assign src_ready = !row_ready;
  assign src_go    = src_valid && src_ready;
  always_ff @(posedge hclk) begin
    if (src_go && (widx < 5'(PAR_WORDS))) begin
      par[4'(widx)] <= (widx < par_len) ? (par[4'(widx)] ^ src_data) : src_data;
    end
  end

  // row bookkeeping; a sent row releases the source side again
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      widx      <= 5'h00;
      par_len   <= 5'h00;
      row_cnt   <= 8'h00;
      row_ready <= 1'b0;
    end else if (tx_done && cur_pay) begin
      row_ready <= 1'b0;
      par_len   <= 5'h00;
    end else if (src_go) begin
      if ((widx >= par_len) && (widx < 5'(PAR_WORDS))) par_len <= widx + 5'h01;
      if (src_last) begin
        widx <= 5'h00;
        if ((row_cnt + 8'h01) >= cfg_row_len) begin
          row_cnt   <= 8'h00;
          row_ready <= 1'b1;
        end else begin
          row_cnt <= row_cnt + 8'h01;
        end
      end else if (widx < 5'(PAR_WORDS)) begin
        widx <= widx + 5'h01;
      end
    end
  end

  // parser never stalls the receive stream
  assign rx_ready = 1'b1;

  // header walk; a frame end always returns to the start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st <= RX_RTP0;
    end else if (rx_valid) begin
      if (rx_last) rx_st <= RX_RTP0;
      else begin
        unique case (rx_st)
          RX_RTP0:  rx_st <= RX_RTP1;
          RX_RTP1:  rx_st <= RX_RTP2;
          RX_RTP2:  rx_st <= RX_FH0;
          RX_FH0:   rx_st <= RX_FH1;
          RX_FH1:   rx_st <= (rx_rtx && rx_fixed) ? RX_SSRC : RX_FH2;
          RX_FH2:   rx_st <= (rx_data[31:24] == 8'h00) ? RX_SKIP : RX_SSRC;
          RX_SSRC:  rx_st <= (rx_rtx && rx_fixed) ? RX_SKIP : RX_BASE;
          RX_BASE:  rx_st <= (!rx_fixed && !rx_data[K_BIT0]) ? RX_EXT1 :
                             ((blk_left > 8'h01) ? RX_SSRC : RX_SKIP);
          RX_EXT1:  rx_st <= !rx_data[K_BIT1] ? RX_EXT2A :
                             ((blk_left > 8'h01) ? RX_SSRC : RX_SKIP);
          RX_EXT2A: rx_st <= RX_EXT2B;
          RX_EXT2B: rx_st <= (blk_left > 8'h01) ? RX_SSRC : RX_SKIP;
          RX_SKIP:  rx_st <= RX_SKIP;
        endcase
      end
    end
  end

  // a block is complete on its last identifier, base or mask word
  assign blk_done = rx_valid && (((rx_st == RX_BASE) && (rx_fixed || rx_data[K_BIT0]))
                  || ((rx_st == RX_EXT1) && rx_data[K_BIT1]) || (rx_st == RX_EXT2B)
                  || ((rx_st == RX_SSRC) && rx_rtx && rx_fixed));

  // recovery fields; reserved bits never looked at
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_rtx    <= 1'b0;
      rx_fixed  <= 1'b0;
      rec_valid <= 1'b0;
      rec_p     <= 1'b0;
      rec_x     <= 1'b0;
      rec_cc    <= 4'h0;
      rec_m     <= 1'b0;
      rec_pt    <= 7'h00;
      rec_len   <= 16'h0000;
      rec_ts    <= 32'h0000_0000;
      rx_drop   <= 1'b0;
      drop_cnt  <= 32'h0000_0000;
      blk_left  <= 8'h00;
    end else begin
      rec_valid <= rx_valid && (rx_st == RX_FH1) && !(rx_rtx && rx_fixed);
      rx_drop   <= rx_valid && (rx_st == RX_FH2) && (rx_data[31:24] == 8'h00);
      if (rx_valid && (rx_st == RX_FH0)) begin
        rx_rtx   <= rx_data[FH_R];
        rx_fixed <= rx_data[FH_F];
        rec_p    <= rx_data[29];
        rec_x    <= rx_data[28];
        rec_cc   <= rx_data[27:24];
        rec_m    <= rx_data[23];
        rec_pt   <= rx_data[22:16];
        if (!(rx_data[FH_R] && rx_data[FH_F])) rec_len <= rx_data[15:0];
        else blk_left <= 8'h01;
      end
      if (rx_valid && (rx_st == RX_FH1)) rec_ts <= rx_data;
      if (rx_valid && (rx_st == RX_FH2)) blk_left <= rx_data[31:24];
      if (rx_valid && (rx_st == RX_FH2) && (rx_data[31:24] == 8'h00)) begin
        drop_cnt <= drop_cnt + 32'h0000_0001;
      end
      if (blk_done) blk_left <= blk_left - 8'h01;
    end
  end

  // per-source block capture and classification
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blk_valid  <= 1'b0;
      blk_ssrc   <= 32'h0000_0000;
      blk_base   <= 16'h0000;
      blk_mode   <= MODE_FLEX;
      blk_mask   <= 109'h0;
      blk_mask_w <= 7'h00;
      blk_stride <= 8'h00;
      blk_groups <= 8'h00;
    end else begin
      blk_valid <= blk_done;
      // retransmitted packet base sits in the length slot
      if (rx_valid && (rx_st == RX_FH0) && rx_data[FH_R] && rx_data[FH_F]) begin
        blk_base   <= rx_data[15:0];
        blk_stride <= 8'h00;
        blk_groups <= 8'h00;
        blk_mode   <= MODE_SINGLE;
      end
      if (rx_valid && (rx_st == RX_SSRC)) blk_ssrc <= rx_data;
      if (rx_valid && (rx_st == RX_BASE)) begin
        blk_base <= rx_data[31:16];
        if (rx_fixed) begin
          blk_stride <= rx_data[15:8];
          blk_groups <= rx_data[7:0];
          if (rx_data[7:0] == 8'h00)      blk_mode <= MODE_ROW_END;
          else if (rx_data[7:0] == 8'h01) blk_mode <= MODE_ROW_MORE;
          else                            blk_mode <= MODE_COLUMN;
        end else begin
          blk_mode   <= MODE_FLEX;
          blk_mask   <= {94'h0, rx_data[CH1_W-1:0]};
          blk_mask_w <= 7'(CH1_W);
        end
      end
      // chunk widths grow with each extension flag
      if (rx_valid && (rx_st == RX_EXT1)) begin
        blk_mask[CH2_W-1:CH1_W] <= rx_data[30:0];
        blk_mask_w              <= 7'(CH2_W);
      end
      if (rx_valid && (rx_st == RX_EXT2A)) blk_mask[CH2A_W-1:CH2_W] <= rx_data[30:0];
      if (rx_valid && (rx_st == RX_EXT2B)) begin
        blk_mask[CH3_W-1:CH2A_W] <= rx_data;
        blk_mask_w               <= 7'(CH3_W);
      end
    end
  end

  assign cov_d = cov_seq - blk_base;
  assign cov_j = cov_d - 16'h0001;

  // column members at stride multiples up to the group count
  for (genvar k = 0; k < 256; k++) begin : g_col
    assign col_hit[k] = (8'(k) <= blk_groups) && ((16'(blk_stride) * 16'(k)) == cov_d);
  end

  // coverage of the last parsed block
  always_comb begin
    unique case (blk_mode)
      // bit j means base plus j plus one
      MODE_FLEX:     hit_now = (cov_d != 16'h0000) && (cov_j < {9'h000, blk_mask_w})
                               && blk_mask[cov_j[6:0]];
      MODE_ROW_END,
      MODE_ROW_MORE: hit_now = cov_d <= {8'h00, blk_stride};
      MODE_COLUMN:   hit_now = |col_hit;
      MODE_SINGLE:   hit_now = cov_d == 16'h0000;
      default:       hit_now = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cov_hit <= 1'b0;
    else cov_hit <= hit_now;
  end

  // checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_marker;
    tx_valid && (tx_cur == W_RTP0) |-> !tx_data[RTP_M];
  endproperty
  a_marker: assert property (p_marker)
    else $error("marker bit set in repair packet");
  property p_seq;
    tx_start && ids_set |=> cur_seq == 16'($past(cur_seq) + 16'h0001);
  endproperty
  a_seq: assert property (p_seq)
    else $error("repair sequence did not step by one");
  property p_seed;
    tx_start && !ids_set |=> cur_seq == 16'($past(lfsr));
  endproperty
  a_seed: assert property (p_seed)
    else $error("first sequence not taken from generator");
  property p_ts;
    tx_start |=> cur_ts == $past(ts_cnt);
  endproperty
  a_ts: assert property (p_ts)
    else $error("send time not captured at start");
  property p_rtx_bit;
    tx_valid && (tx_cur == W_FH0) |-> (tx_data[FH_R] == cur_rtx) && (tx_data[FH_F] == cur_fixed);
  endproperty
  a_rtx_bit: assert property (p_rtx_bit)
    else $error("retransmit or mask type bit wrong");
  property p_rec;
    rx_valid && !rx_last && (rx_st == RX_FH0) && !(rx_data[FH_R] && rx_data[FH_F])
      |=> rec_len == 16'($past(rx_data));
  endproperty
  a_rec: assert property (p_rec)
    else $error("length recovery not captured");
  property p_drop;
    rx_valid && !rx_last && (rx_st == RX_FH2) && (rx_data[31:24] == 8'h00)
      |=> rx_drop && (rx_st == RX_SKIP) ##1 !blk_valid;
  endproperty
  a_drop: assert property (p_drop)
    else $error("zero source count not discarded");
  property p_resv;
    tx_valid && (tx_cur == W_FH2) && !single |-> tx_data[23:0] == 24'h00_0000;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bits not zero");
  property p_ext;
    rx_valid && !rx_last && (rx_st == RX_BASE) && !rx_fixed && !rx_data[K_BIT0]
      |=> rx_st == RX_EXT1;
  endproperty
  a_ext: assert property (p_ext)
    else $error("mask extension not followed");
  property p_single;
    blk_mode == MODE_SINGLE |=> cov_hit == ($past(cov_seq) == $past(blk_base));
  endproperty
  a_single: assert property (p_single)
    else $error("single packet coverage wrong");
  property p_rtx_len;
    tx_start && cfg_rtx && cfg_fixed |=> tx_total == RTX_WORDS;
  endproperty
  a_rtx_len: assert property (p_rtx_len)
    else $error("retransmission header length wrong");

  c_ext2: cover property (rx_valid && (rx_st == RX_EXT2B));
  c_drop: cover property (rx_drop);
  c_rtx:  cover property (tx_valid && tx_last && single);
  c_col:  cover property (blk_valid && (blk_mode == MODE_COLUMN));
endmodule

/* File: verilog/pfhc_pkg.sv */
// pfhc_pkg: constants and types for the parity repair header codec
// assumes one 40 MHz clock, an AHB-Lite register port and 32-bit word streams
package pfhc_pkg;
  // timing
  localparam int CLK_HZ     = 40_000_000;
  localparam int TS_RATE_HZ = 90_000;
  localparam int TS_DIV_CYC = CLK_HZ / TS_RATE_HZ;
  // pseudo random generator, seed is arbitrary
  localparam logic [31:0] LFSR_SEED = 32'hACE1_2D5B;
  localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_REC      = 8'h04;
  localparam logic [7:0] OFF_TSREC    = 8'h08;
  localparam logic [7:0] OFF_SRC_SSRC = 8'h0C;
  localparam logic [7:0] OFF_BASE     = 8'h10;
  localparam logic [7:0] OFF_CFG      = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  localparam logic [7:0] OFF_REP_SSRC = 8'h1C;
  localparam logic [7:0] OFF_DROP     = 8'h20;
  // reset values
  localparam logic [6:0] RST_PT      = 7'h60;
  localparam logic [7:0] RST_ROW_LEN = 8'h04;
  // control bit positions
  localparam int BIT_START = 0;
  localparam int BIT_RTX   = 1;
  localparam int BIT_FIXED = 2;
  // header field positions
  localparam int FH_R   = 31;
  localparam int FH_F   = 30;
  localparam int RTP_M  = 23;
  localparam int K_BIT0 = 15;
  localparam int K_BIT1 = 31;
  localparam logic [1:0] RTP_VER = 2'h2;
  // word indexes of the emitted frame
  localparam logic [4:0] W_RTP0 = 5'h00;
  localparam logic [4:0] W_TS   = 5'h01;
  localparam logic [4:0] W_SSRC = 5'h02;
  localparam logic [4:0] W_FH0  = 5'h03;
  localparam logic [4:0] W_FH1  = 5'h04;
  localparam logic [4:0] W_FH2  = 5'h05;
  localparam logic [4:0] W_SRC  = 5'h06;
  localparam logic [4:0] W_BLK  = 5'h07;
  localparam logic [4:0] HDR_WORDS = 5'h08;
  localparam logic [4:0] RTX_WORDS = 5'h06;
  // parity buffer depth in words
  localparam int PAR_WORDS = 16;
  // flexible mask chunk ends
  localparam int CH1_W  = 15;
  localparam int CH2_W  = 46;
  localparam int CH2A_W = 77;
  localparam int CH3_W  = 109;
  typedef enum logic [3:0] {
    RX_RTP0, RX_RTP1, RX_RTP2, RX_FH0, RX_FH1, RX_FH2,
    RX_SSRC, RX_BASE, RX_EXT1, RX_EXT2A, RX_EXT2B, RX_SKIP
  } pfhc_rx_t;
  typedef enum logic [2:0] {
    MODE_FLEX, MODE_ROW_END, MODE_ROW_MORE, MODE_COLUMN, MODE_SINGLE
  } pfhc_mode_t;
endpackage

/* File: verif/pfhc_peer.sv */
// pfhc_peer: remote endpoint that sinks repair frames
// assumes tx stream on hclk; stalls one beat in four to test hold
`timescale 1ns/1ps
module pfhc_peer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        tx_valid,
  input  wire logic        tx_last,
  input  wire logic [31:0] tx_data,
  output logic             tx_ready
);
  logic [31:0] words [0:15];
  logic [1:0]  ph;
  int          n;
  int          nf;
  // back-pressure pattern, a real sink is no kinder
  assign tx_ready = (ph != 2'h3);
  // capture accepted words, count whole frames
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph <= 2'h0;
      n  <= 0;
      nf <= 0;
    end else begin
      ph <= ph + 2'h1;
      if (tx_valid && tx_ready) begin
        words[n] <= tx_data;
        n        <= tx_last ? 0 : n + 1;
        nf       <= nf + (tx_last ? 1 : 0);
      end
    end
  end
endmodule

/* File: verif/tb.sv */
// tb: register, repair send and header parse scenarios
// assumes an AHB-Lite slave that may insert waits, and the peer model as sink
`timescale 1ns/1ps
module tb;
  import pfhc_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rx_valid = 0, rx_last = 0;
  logic [31:0] haddr = 0, hwdata = 0, rx_data = 0, r, w0;
  logic [1:0]  htrans = 0;
  logic [15:0] cov_seq = 0;
  logic        drop = 0;
  logic        src_valid = 0, src_last = 0;
  logic [31:0] src_data = 0;
  wire         hresp, src_ready, rx_ready, rec_valid, rec_p, rec_x, rec_m, blk_valid;
  wire [3:0]   rec_cc;
  wire [7:0]   blk_stride, blk_groups;
  wire [31:0]  blk_ssrc;
  wire [108:0] blk_mask;
  wire         hreadyout, tx_valid, tx_ready, tx_last, rx_drop, cov_hit;
  wire [31:0]  hrdata, tx_data, rec_ts;
  wire [15:0]  rec_len, blk_base;
  wire [6:0]   rec_pt, blk_mask_w;
  pfhc_mode_t  blk_mode;
  int          n_fail = 0, tests_run = 0, cyc = 0, nblk = 0, nrec = 0;
  pfhc_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .src_valid, .src_ready, .src_data,
    .src_last, .tx_valid, .tx_ready, .tx_data, .tx_last, .rx_valid, .rx_ready, .rx_data,
    .rx_last, .rx_drop, .rec_valid, .rec_p, .rec_x, .rec_cc, .rec_m, .rec_pt, .rec_len,
    .rec_ts, .blk_valid, .blk_ssrc, .blk_base, .blk_mode, .blk_mask, .blk_mask_w,
    .blk_stride, .blk_groups, .cov_seq, .cov_hit);
  pfhc_peer peer (.hclk, .hresetn, .tx_valid, .tx_last, .tx_data, .tx_ready);
  initial forever #12.5 hclk = ~hclk;
  // sticky copy of the one-cycle drop pulse, counts of block and recovery pulses
  always @(posedge hclk) begin
    if (rx_drop === 1'b1) drop <= 1'b1;
    if (blk_valid === 1'b1) nblk <= nblk + 1;
    if (rec_valid === 1'b1) nrec <= nrec + 1;
  end
  task complete_run;
    $display("counts: fail=%0d run=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, the whole run needs a few hundred cycles
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // one single AHB transfer; each phase held until hready is seen high at a rising edge
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      r = hrdata;
    end while (hreadyout !== 1'b1);
  endtask
  // flags are latched a write ahead, since a start takes the flags already held
  task send(input logic [31:0] c);
    int k;
    bus(1, 32'(OFF_CTRL), c & 32'hFFFF_FFFE);
    k = peer.nf;
    bus(1, 32'(OFF_CTRL), c);
    for (int i = 0; i < 400 && peer.nf == k; i++) @(posedge hclk);
    chk(peer.nf, k + 1);
  endtask
  task t_tx;
    bus(0, 32'(OFF_CFG), 0); chk(r, 32'h0000_0460);
    bus(0, 32'h0000_0024, 0); chk(r, 32'h0);
    bus(1, 32'(OFF_REC), 32'h1234_5678);
    bus(1, 32'(OFF_TSREC), 32'hCAFE_0001);
    bus(1, 32'(OFF_SRC_SSRC), 32'h0BAD_F00D);
    bus(1, 32'(OFF_BASE), 32'h0064_0003);
    send(1); w0 = peer.words[0];
    chk(w0[23], 0);
    chk(peer.words[3], 32'h1234_5678);
    chk(peer.words[4], 32'hCAFE_0001);
    chk(peer.words[5], 32'h0100_0000);
    chk(peer.words[6], 32'h0BAD_F00D);
    chk(peer.words[7], 32'h0064_8003);
    send(1); chk(peer.words[0][15:0], 16'(w0[15:0] + 16'h1));
    send(7); chk(peer.words[3], 32'hD234_0064);
    chk(peer.words[5], 32'h0BAD_F00D);
    chk(peer.words[0][15:0], 16'(w0[15:0] + 16'h2));
  endtask
  // four two-word packets fill one row, the next frame carries their parity
  task t_par;
    for (int i = 0; i < 8; i++) begin
      src_valid <= 1;
      src_data  <= i[0] ? (32'h0000_0010 << i[2:1]) : (32'h0101_0101 << i[2:1]);
      src_last  <= i[0];
      do @(posedge hclk); while (src_ready !== 1'b1);
    end
    src_valid <= 0;
    src_last  <= 0;
    @(posedge hclk);
    chk(src_ready, 0);
    send(1);
    chk(peer.words[8], 32'h0F0F_0F0F);
    chk(peer.words[9], 32'h0000_00F0);
    chk(src_ready, 1);
  endtask
  task rxf(input logic [31:0] fh, input logic [31:0] cnt, input logic [31:0] base);
    logic [31:0] a [8];
    a = '{32'h8060_0001, 0, 1, fh, 32'h5555_AAAA, cnt, 32'h0BAD_F00D, base};
    for (int i = 0; i < 8; i++) begin
      @(posedge hclk); rx_valid <= 1; rx_data <= a[i]; rx_last <= (i == 7);
    end
    @(posedge hclk); rx_valid <= 0; rx_last <= 0;
    repeat (2) @(posedge hclk);
  endtask
  task t_rx;
    rxf(32'h00E1_0100, 32'h0, 32'h0010_8005); chk(drop, 1);
    chk({hresp, rx_ready}, 32'h1);
    rxf(32'h25E1_0100, 32'h01FF_FFFF, 32'h0010_8005); // reserved bits set
    chk(rec_pt, 7'h61);
    chk({rec_p, rec_x, rec_cc, rec_m}, 7'h4B);
    chk(blk_ssrc, 32'h0BAD_F00D);
    chk(blk_mask[14:0], 15'h0005);
    chk(rec_len, 16'h0100);
    chk(rec_ts, 32'h5555_AAAA);
    chk(blk_mode, MODE_FLEX);
    chk(blk_mask_w, 7'd15);
    chk(blk_base, 16'h0010);
    cov_seq <= 16'h0012; repeat (2) @(posedge hclk); #1 chk(cov_hit, 0);
    cov_seq <= 16'h0013; repeat (2) @(posedge hclk); #1 chk(cov_hit, 1);
    for (int n = 0; n < 3; n++) begin
      rxf(32'h4000_0000, 32'h0100_0000, 32'h0010_0400 | n);
      chk(blk_mode, n + 1);
      chk({blk_stride, blk_groups}, {8'h04, 8'(n)});
      cov_seq <= 16'h0018;
      repeat (2) @(posedge hclk);
      #1 chk(cov_hit, n == 2);
    end
    // retransmission layout: base in the length slot, identifier right after
    rxf(32'hC000_0020, 32'h0BAD_BEEF, 32'h0);
    chk(blk_mode, MODE_SINGLE);
    chk(blk_base, 16'h0020);
    chk(blk_ssrc, 32'h0BAD_BEEF);
    cov_seq <= 16'h0020;
    repeat (2) @(posedge hclk);
    #1 chk(cov_hit, 1);
    chk(nblk, 5);
    chk(nrec, 5);
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    t_tx;
    t_par;
    t_rx;
    complete_run;
  end
endmodule
